// [rtl/dnot_consts.vh]
// named constants for the nominal termination control block
// assumes the includer runs on a 50 MHz system clock
`ifndef DNOT_CONSTS_VH
`define DNOT_CONSTS_VH

// termination code field, three bits
`define DNOT_CODE_W        3
`define DNOT_CODE_OFF      3'h0
`define DNOT_CODE_RZQ4     3'h1
`define DNOT_CODE_RZQ2     3'h2
`define DNOT_CODE_RZQ6     3'h3
`define DNOT_CODE_RZQ12    3'h4
`define DNOT_CODE_RZQ8     3'h5
`define DNOT_CODE_RSV0     3'h6
`define DNOT_CODE_RSV1     3'h7

// divisor codes of the calibration reference
`define DNOT_DIV_W         4
`define DNOT_DIV_NONE      4'h0
`define DNOT_DIV_2         4'h2
`define DNOT_DIV_4         4'h4
`define DNOT_DIV_6         4'h6
`define DNOT_DIV_8         4'h8
`define DNOT_DIV_12        4'hc
`define DNOT_RZQ_OHM       240

// latency inputs and history depth
`define DNOT_LAT_W         5
`define DNOT_SUM_W         6
`define DNOT_LAT_OFFSET    6'h02
`define DNOT_HIST_DEPTH    32
`define DNOT_HIST_MAX      6'h1f

// asynchronous delay window and system clock period, picoseconds
`define DNOT_ASYNC_MIN_PS  2000
`define DNOT_ASYNC_MAX_PS  8500
`define DNOT_CLK_PS        20000

`endif

// [rtl/dnot_ctrl.v]
// nominal on-die termination control of the memory device
// assumes memory clock, control ball and reset ball arrive asynchronous
// to clk; state inputs come from logic on clk
// every pad-relative latency carries the fixed two-flop sync delay on top,
// since clock and ball are both seen through their synchronisers
// outputs are registered; each pad enable changes one clk after its cause
`timescale 1ns/1ns
`default_nettype none
`include "dnot_consts.vh"

module dnot_ctrl (
    input  wire                       clk,
    input  wire                       sys_rst,
    input  wire                       mem_ck,
    input  wire                       odt_ball,
    input  wire                       reset_ball_n,
    input  wire [`DNOT_CODE_W-1:0]    rtt_code,
    input  wire [`DNOT_LAT_W-1:0]     cwl,
    input  wire [`DNOT_LAT_W-1:0]     al,
    input  wire                       self_refresh,
    input  wire                       read_active,
    input  wire                       write_active,
    input  wire                       dll_disabled,
    input  wire                       dll_relocking,
    input  wire                       slow_pd_async,
    input  wire                       cfg_x16,
    input  wire                       tdqs_enable,
    output reg                        term_lower_en,
    output reg                        term_upper_en,
    output reg                        term_tdqs_en,
    output reg  [`DNOT_DIV_W-1:0]     rtt_div,
    output reg                        code_illegal,
    output reg                        write_value_bad,
    output reg                        async_mode
);

    // asynchronous delay in clk cycles: least rounds up, longest down, both at least one
    // at this system clock the whole window is shorter than one cycle, so the
    // path is one cycle long; it keeps the order of events, not the window
    // as measured at the pad
    localparam integer ASYNC_MIN_RAW = (`DNOT_ASYNC_MIN_PS + `DNOT_CLK_PS - 1) / `DNOT_CLK_PS;
    localparam integer ASYNC_MAX_RAW = `DNOT_ASYNC_MAX_PS / `DNOT_CLK_PS;
    localparam integer ASYNC_MIN_CYC = (ASYNC_MIN_RAW < 1) ? 1 : ASYNC_MIN_RAW;
    localparam integer ASYNC_MAX_CYC = (ASYNC_MAX_RAW < 1) ? 1 : ASYNC_MAX_RAW;
    localparam integer ASYNC_CYC     = (ASYNC_MIN_CYC > ASYNC_MAX_CYC) ? ASYNC_MIN_CYC : ASYNC_MAX_CYC;

    // two-flop synchronisers; stage one is read by stage two only
    // the reset ball stages clear low, so termination stays forced off
    // until the ball has been seen high twice
    reg                               ck_s1_q;
    reg                               ck_s2_q;
    reg                               ck_prev_q;
    reg                               odt_s1_q;
    reg                               odt_s2_q;
    reg                               rstb_s1_q;
    reg                               rstb_s2_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            ck_s1_q   <= 1'b0;
            ck_s2_q   <= 1'b0;
            ck_prev_q <= 1'b0;
            odt_s1_q  <= 1'b0;
            odt_s2_q  <= 1'b0;
            rstb_s1_q <= 1'b0;
            rstb_s2_q <= 1'b0;
        end else begin
            ck_s1_q   <= mem_ck;
            ck_s2_q   <= ck_s1_q;
            ck_prev_q <= ck_s2_q;
            odt_s1_q  <= odt_ball;
            odt_s2_q  <= odt_s1_q;
            rstb_s1_q <= reset_ball_n;
            rstb_s2_q <= rstb_s1_q;
        end
    end

    // memory clock edges seen on clk; ball and clock share sync delay
    wire                              ck_rise = ck_s2_q & ~ck_prev_q;
    wire                              ck_fall = ~ck_s2_q & ck_prev_q;

    // synchronous latency in memory clocks, clamped at zero and at DNOT_HIST_MAX, 31
    // the sum is six bits wide, so cwl plus al never wraps
    // a latency beyond DNOT_HIST_MAX is held at tap 31, one short of the deepest, a
    // limitation for settings far above any usable write latency
    wire [`DNOT_SUM_W-1:0]            lat_sum = {1'b0, cwl} + {1'b0, al};
    reg  [`DNOT_SUM_W-1:0]            lat_d;

    always @* begin
        if (lat_sum < `DNOT_LAT_OFFSET) begin
            lat_d = {`DNOT_SUM_W{1'b0}};
        end else if (lat_sum - `DNOT_LAT_OFFSET > `DNOT_HIST_MAX) begin
            lat_d = `DNOT_HIST_MAX;
        end else begin
            lat_d = lat_sum - `DNOT_LAT_OFFSET;
        end
    end

    // history of ball samples, one per memory clock rising edge
    // the history keeps shifting in asynchronous mode too, so a return to
    // synchronous mode finds an up-to-date level waiting
    reg  [`DNOT_HIST_DEPTH-1:0]       hist_q;
    reg                               sync_pend_q;
    reg                               sync_on_q;
    wire [`DNOT_HIST_DEPTH:0]         hist_ext = {hist_q, odt_s2_q};

    always @(posedge clk) begin
        if (sys_rst || !rstb_s2_q) begin
            hist_q      <= {`DNOT_HIST_DEPTH{1'b0}};
            sync_pend_q <= 1'b0;
            sync_on_q   <= 1'b0;
        end else begin
            if (ck_rise) begin
                hist_q      <= hist_ext[`DNOT_HIST_DEPTH-1:0];
                // level registered lat clocks ago reaches the pad now
                sync_pend_q <= hist_ext[lat_d];
            end
            // half a memory clock of skew after the latency ends
            if (ck_fall) begin
                sync_on_q <= sync_pend_q;
            end
        end
    end

    // asynchronous path: a short fixed delay straight from the ball
    reg  [ASYNC_CYC-1:0]              async_dly_q;
    wire [ASYNC_CYC:0]                async_ext = {async_dly_q, odt_s2_q};

    always @(posedge clk) begin
        if (sys_rst || !rstb_s2_q) begin
            async_dly_q <= {ASYNC_CYC{1'b0}};
        end else begin
            async_dly_q <= async_ext[ASYNC_CYC-1:0];
        end
    end

    // power-down and relock both lose the clock alignment the latency needs
    wire                              async_now = slow_pd_async | dll_relocking;
    wire                              async_on  = async_dly_q[ASYNC_CYC-1];

    // nominal value lookup from the three-bit code
    // the divisor is shown even while the ball keeps termination off, so
    // the pad driver can settle its value ahead of turn-on
    reg  [`DNOT_DIV_W-1:0]            div_d;
    reg                               code_bad_d;

    always @* begin
        code_bad_d = 1'b0;
        case (rtt_code)
            `DNOT_CODE_OFF:   div_d = `DNOT_DIV_NONE;
            `DNOT_CODE_RZQ4:  div_d = `DNOT_DIV_4;
            `DNOT_CODE_RZQ2:  div_d = `DNOT_DIV_2;
            `DNOT_CODE_RZQ6:  div_d = `DNOT_DIV_6;
            `DNOT_CODE_RZQ12: div_d = `DNOT_DIV_12;
            `DNOT_CODE_RZQ8:  div_d = `DNOT_DIV_8;
            default: begin
                // reserved codes: refuse to terminate rather than guess
                div_d      = `DNOT_DIV_NONE;
                code_bad_d = 1'b1;
            end
        endcase
    end

    // write-time value check: only the three weakest settings are fit
    // code off counts as fit: nothing is applied, so nothing can be wrong
    wire                              wr_value_ok = (div_d == `DNOT_DIV_2) | (div_d == `DNOT_DIV_4) |
                                                    (div_d == `DNOT_DIV_6) | (div_d == `DNOT_DIV_NONE);

    // gating of the ball-driven level by device state
    // read and self refresh gate the level directly, not through the latency,
    // trading pad-exact timing for never terminating into a read burst
    wire                              code_on = (rtt_code != `DNOT_CODE_OFF) & ~code_bad_d;
    wire                              state_ok = ~self_refresh & ~read_active & ~dll_disabled;
    wire                              ball_on = async_now ? async_on : sync_on_q;
    wire                              term_d = rstb_s2_q & code_on & state_ok & ball_on;

    // registered outputs; reset ball low forces every lane off
    // x16 parts never carry the termination strobe pair, whatever tdqs says
    // write_value_bad only warns; termination is still applied as programmed
    // dynamic write termination takes no part in term_d
    always @(posedge clk) begin
        if (sys_rst || !rstb_s2_q) begin
            term_lower_en   <= 1'b0;
            term_upper_en   <= 1'b0;
            term_tdqs_en    <= 1'b0;
            rtt_div         <= `DNOT_DIV_NONE;
            code_illegal    <= 1'b0;
            write_value_bad <= 1'b0;
            async_mode      <= 1'b0;
        end else begin
            term_lower_en   <= term_d;
            term_upper_en   <= term_d & cfg_x16;
            term_tdqs_en    <= term_d & tdqs_enable & ~cfg_x16;
            rtt_div         <= code_on ? div_d : `DNOT_DIV_NONE;
            code_illegal    <= code_bad_d;
            write_value_bad <= write_active & term_d & ~wr_value_ok;
            async_mode      <= async_now;
        end
    end

endmodule
`default_nettype wire

// [verif/dnot_ctrl_assertions.sv]
// assertions on the termination control ports
// assumes a bind into dnot_ctrl, everything on clk
`timescale 1ns/1ns
`default_nettype none
`include "dnot_consts.vh"
module dnot_chk (
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire logic                    reset_ball_n,
    input wire logic [`DNOT_CODE_W-1:0] rtt_code,
    input wire logic                    read_active,
    input wire logic                    self_refresh,
    input wire logic                    dll_disabled,
    input wire logic                    dll_relocking,
    input wire logic                    slow_pd_async,
    input wire logic                    cfg_x16,
    input wire logic                    term_lower_en,
    input wire logic                    term_upper_en,
    input wire logic                    term_tdqs_en,
    input wire logic [`DNOT_DIV_W-1:0]  rtt_div,
    input wire logic                    code_illegal,
    input wire logic                    async_mode
);
    // one domain, so clock and reset are shared
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_rsv_flag: assert property (!$past(sys_rst) && $stable(rtt_code) && rtt_code[2:1] == 2'h3
        |-> code_illegal) else $error("reserved code not flagged");
    a_rsv_off: assert property (code_illegal |-> !term_lower_en && rtt_div == 4'h0)
        else $error("reserved code left termination on");
    a_code_off: assert property ($stable(rtt_code) && rtt_code == 3'h0 |-> !term_lower_en)
        else $error("code off but termination on");
    a_read_gate: assert property (read_active || self_refresh
        |=> !term_lower_en && !term_upper_en && !term_tdqs_en) else $error("termination on in read or refresh");
    a_dll_gate: assert property (dll_disabled |=> !(term_lower_en || term_upper_en || term_tdqs_en))
        else $error("termination on with dll disabled");
    // the reset ball reaches the outputs three edges late through its synchroniser
    a_async_mode: assert property (!$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
        && $past(reset_ball_n, 3) |-> async_mode == ($past(slow_pd_async) || $past(dll_relocking)))
        else $error("async mode wrong");
    a_rstball_off: assert property (!$past(reset_ball_n, 3)
        |-> !term_lower_en && !term_upper_en && !term_tdqs_en)
        else $error("termination on with reset ball low");
    a_x8_upper: assert property (!cfg_x16 |=> !term_upper_en)
        else $error("upper lane on in x8");
    a_div_legal: assert property (term_lower_en |-> rtt_div inside {4'h2, 4'h4, 4'h6, 4'h8, 4'hc})
        else $error("termination on without legal value");
endmodule
`default_nettype wire

// [verif/dnot_ctrl_test.sv]
// self-checking test of the nominal termination control
// assumes dnot_mc as controller model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "dnot_consts.vh"
module dnot_ctrl_test;
    logic clk, sys_rst, reset_ball_n, self_refresh, read_active, write_active, dll_disabled;
    logic dll_relocking, slow_pd_async, cfg_x16, tdqs_enable, term_lower_en, term_upper_en, term_tdqs_en;
    logic code_illegal, write_value_bad, async_mode;
    logic [`DNOT_CODE_W-1:0] rtt_code;
    logic [`DNOT_LAT_W-1:0]  cwl, al;
    logic [`DNOT_DIV_W-1:0]  rtt_div;
    wire                     mem_ck, odt_ball;
    int                      error_cnt = 0, checks_done = 0;
    logic [3:0]              divs [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hc, 4'h8, 4'h0, 4'h0};
    dnot_mc ctl (.mem_ck, .odt_ball);
    dnot_ctrl dut (.clk, .sys_rst, .mem_ck, .odt_ball, .reset_ball_n, .rtt_code, .cwl, .al, .self_refresh,
        .read_active, .write_active, .dll_disabled, .dll_relocking, .slow_pd_async, .cfg_x16, .tdqs_enable,
        .term_lower_en, .term_upper_en, .term_tdqs_en, .rtt_div, .code_illegal, .write_value_bad, .async_mode);
    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // ball edge then probe just before and just after the latency ends
    task automatic sync_run(input logic [4:0] w, input logic [4:0] a, input logic lvl);
        repeat (8) @(posedge mem_ck);
        ctl.drive_odt(lvl);
        repeat (w + a - 1) @(posedge mem_ck);
        #40 check("sync early", 4'(term_lower_en), 4'(!lvl));
        @(posedge mem_ck);
        #80 check("sync late", 4'(term_lower_en), 4'(lvl));
    endtask
    // hang guard, well past the expected run
    initial begin
        #200000;
        error_cnt++;
        report_and_stop;
    end
    initial begin
        {sys_rst, reset_ball_n, self_refresh, read_active, write_active, dll_disabled} = 6'h30;
        {dll_relocking, slow_pd_async, cfg_x16, tdqs_enable} = 4'h0;
        rtt_code = 3'h2;
        cwl = 5'h5;
        al = 5'h0;
        cyc(3);
        sys_rst = 1'b0;
        check("reset", {term_lower_en, code_illegal, async_mode, term_upper_en}, 4'h0);
        // ball first raised only after reset and init, with no read pending
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            cwl = i < 2 ? 5'h5 : 5'h6;
            al = i < 2 ? 5'h0 : 5'h2;
            sync_run(cwl, al, i[0] == 1'b0);
        end
        $display("sync latency done");
        cyc(1);
        slow_pd_async = 1'b1;
        ctl.drive_odt(1'b1);
        cyc(1);
        for (int c = 0; c < 8; c++) begin
            rtt_code = 3'(c);
            cyc(6);
            check("divisor", rtt_div, divs[c]);
            check("on", 4'(term_lower_en), 4'(c > 0 && c < 6));
            check("illegal", 4'(code_illegal), 4'(c > 5));
        end
        check("async", 4'(async_mode), 4'h1);
        $display("codes done");
        rtt_code = 3'h2;
        for (int g = 0; g < 4; g++) begin
            {read_active, self_refresh, dll_disabled} = 3'(4'h1 << g);
            cyc(2);
            check("gate", 4'(term_lower_en), 4'(g == 3));
        end
        $display("gating done");
        {cfg_x16, tdqs_enable} = 2'h3;
        cyc(3);
        check("x16", {term_upper_en, term_tdqs_en, term_lower_en}, 4'h5);
        cfg_x16 = 1'b0;
        cyc(3);
        check("x8 tdqs", {term_upper_en, term_tdqs_en, term_lower_en}, 4'h3);
        $display("lanes done");
        // writes run with the ball kept high
        {slow_pd_async, dll_relocking, write_active} = 3'h3;
        for (int c = 1; c < 6; c++) begin
            rtt_code = 3'(c);
            cyc(6);
            check("write value", 4'(write_value_bad), 4'(c == 4 || c == 5));
        end
        write_active = 1'b0;
        cyc(2);
        check("write idle", 4'(write_value_bad), 4'h0);
        $display("write value done");
        dll_relocking = 1'b0;
        reset_ball_n = 1'b0;
        cyc(6);
        check("reset ball", {term_lower_en, term_tdqs_en, async_mode}, 4'h0);
        // ball dropped ahead of the read, then the reset ball released
        ctl.drive_odt(1'b0);
        cyc(1);
        {read_active, reset_ball_n} = 2'h3;
        cyc(6);
        check("read", 4'(term_lower_en), 4'h0);
        read_active = 1'b0;
        sync_run(cwl, al, 1'b1);
        $display("reset ball done");
        report_and_stop;
    end
endmodule
bind dnot_ctrl dnot_chk chk (.clk, .sys_rst, .reset_ball_n, .rtt_code, .read_active, .self_refresh, .dll_disabled,
    .dll_relocking, .slow_pd_async, .cfg_x16, .term_lower_en, .term_upper_en, .term_tdqs_en, .rtt_div,
    .code_illegal, .async_mode);
`default_nettype wire

// [verif/dnot_mc.sv]
// memory controller side: memory clock and control ball
// assumes one caller of drive_odt at a time
`timescale 1ns/1ns
`default_nettype none
module dnot_mc (
    output logic mem_ck,
    output logic odt_ball
);
    logic [2:0] hi_cnt = 3'h0;
    // memory clock runs free, phase unrelated to clk
    initial begin
        mem_ck = 1'b0;
        odt_ball = 1'b0;
        #7;
        forever #80 mem_ck = ~mem_ck;
    end
    // saturating count of memory clocks with the ball high
    always @(posedge mem_ck) hi_cnt <= odt_ball ? hi_cnt + {2'h0, hi_cnt != 3'h7} : 3'h0;
    // ball moves after a falling edge, clear of the sampling rise
    task automatic drive_odt(input logic lvl);
        while (!lvl && odt_ball && hi_cnt < 3'h6) @(posedge mem_ck);
        @(negedge mem_ck);
        odt_ball = lvl;
    endtask
endmodule
`default_nettype wire
